// *** hdl/lsc_defines.vh ***
/*
 * constants of the dish supply control logic: register map, bit fields,
 * bus address codes and protection timing.
 * assumes a 125 mhz mclk; included by the control module only.
 */
`ifndef LSC_DEFINES_VH
`define LSC_DEFINES_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define LSC_ADDR_CTRL 4'h0
`define LSC_ADDR_STAT 4'h4
`define LSC_ADDR_IRQ 4'h8
`define LSC_ADDR_MASK 4'hc

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define LSC_C_EN 0
`define LSC_C_VHI 1
`define LSC_C_LLB 2
`define LSC_C_TGEN 3
`define LSC_C_TPATH 4
`define LSC_C_CLAMP 5
`define LSC_C_RANGE 6
`define LSC_C_AUX 7
`define LSC_CTRL_W 8
`define LSC_CTRL_RST 8'h00

// ----------------------------------------------------------------
// status register fields (also irq layout)
// ----------------------------------------------------------------
`define LSC_S_OL 0
`define LSC_S_OT 1
`define LSC_S_TONE 2
`define LSC_S_VLOW 3
`define LSC_S_IMIN 4
`define LSC_FLAG_W 5
`define LSC_FLAG_RST 5'h00

// ----------------------------------------------------------------
// bus address codes and output level codes
// ----------------------------------------------------------------
`define LSC_BUS_ADDR_LO 7'h02
`define LSC_BUS_ADDR_HI 7'h03
`define LSC_LVL_OFF 3'h0
`define LSC_LVL_13V4 3'h1
`define LSC_LVL_18V5 3'h2
`define LSC_LVL_19V5 3'h3
`define LSC_LVL_22V 3'h4
`define LSC_PP_OFFSET_V 5

// ----------------------------------------------------------------
// timing: one millisecond tick, overload on and off periods
// ----------------------------------------------------------------
`define LSC_CLK_MHZ 125
`define LSC_MS_CYCLES (`LSC_CLK_MHZ * 1000)
`define LSC_OL_ON_MS 90
`define LSC_OL_OFF_MS 900

`define LSC_RESP_OKAY 2'b00
`define LSC_RESP_SLVERR 2'b10

`endif

// *** hdl/lsc_supply_ctrl.v ***
/*
 * control and protection logic of the dish supply regulator: register
 * file over axi4-lite, level select, tone path gating, timed overload
 * shutdown or static clamp, minimum current diagnostic, flags, irq.
 * assumes analog monitor inputs arrive asynchronously and the analog
 * regulator follows the level and enable outputs.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defines.vh"

module lsc_supply_ctrl #(
    parameter [31:0] MS_CYCLES = `LSC_MS_CYCLES
) (
    input wire mclk,
    input wire reset_n,
    // axi4-lite slave
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // pins and analog monitors
    input wire addr_sel_pin,
    input wire tone_gate_pin,
    input wire undervoltage_in,
    input wire overload_in,
    input wire overheat_in,
    input wire tone_bad_in,
    input wire vout_low_in,
    input wire min_current_in,
    // regulator controls
    output reg [2:0] output_level,
    output reg output_enable,
    output reg push_pull_output_pin,
    output reg tone_out_en,
    output reg static_current_clamp,
    output reg diag_current_range,
    output reg [6:0] bus_address,
    output reg shutdown,
    output reg irq
);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    reg [7:0] sync1_q;
    reg [7:0] sync2_q;
    wire [7:0] pins_raw = {min_current_in, vout_low_in, tone_bad_in,
        overheat_in, overload_in, undervoltage_in, tone_gate_pin,
        addr_sel_pin};

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    wire addr_pin_s = sync2_q[0];
    wire gate_s = sync2_q[1];
    wire uv_s = sync2_q[2];
    wire ol_s = sync2_q[3];
    wire [4:0] mon_s = {sync2_q[7:4], 1'b0};

    // ----------------------------------------------------------------
    // millisecond tick
    // ----------------------------------------------------------------
    reg [31:0] ms_cnt_q;
    reg ms_tick_q;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ms_cnt_q <= 32'h0000_0000;
            ms_tick_q <= 1'b0;
        end else if (ms_cnt_q >= MS_CYCLES - 32'h0000_0001) begin
            ms_cnt_q <= 32'h0000_0000;
            ms_tick_q <= 1'b1;
        end else begin
            ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
            ms_tick_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // register file and axi4-lite slave
    // ----------------------------------------------------------------
    reg [`LSC_CTRL_W-1:0] ctrl_q;
    reg [`LSC_FLAG_W-1:0] irq_stat_q;
    reg [`LSC_FLAG_W-1:0] mask_q;
    reg [`LSC_FLAG_W-1:0] flags_q;
    reg [3:0] aw_addr_q;
    reg aw_have_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg w_have_q;
    wire [`LSC_FLAG_W-1:0] flag_rise;
    reg [`LSC_FLAG_W-1:0] flags_prev_q;

    function known_addr;
        input [3:0] a;
        begin
            known_addr = (a == `LSC_ADDR_CTRL) || (a == `LSC_ADDR_STAT) ||
                (a == `LSC_ADDR_IRQ) || (a == `LSC_ADDR_MASK);
        end
    endfunction

    function [7:0] merge_byte;
        input [7:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge_byte = strb[0] ? data[7:0] : old;
        end
    endfunction

    wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    wire do_read = s_axi_arvalid && s_axi_arready;
    wire irq_read = do_read && (s_axi_araddr == `LSC_ADDR_IRQ);
    assign flag_rise = flags_q & ~flags_prev_q;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LSC_RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            ctrl_q <= `LSC_CTRL_RST;
            mask_q <= `LSC_FLAG_RST;
        end else if (uv_s) begin
            ctrl_q <= `LSC_CTRL_RST;
            mask_q <= `LSC_FLAG_RST;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready;
            s_axi_wready <= !w_have_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= known_addr(aw_addr_q) ? `LSC_RESP_OKAY :
                    `LSC_RESP_SLVERR;
                if (aw_addr_q == `LSC_ADDR_CTRL)
                    ctrl_q <= merge_byte(ctrl_q, w_data_q, w_strb_q);
                if (aw_addr_q == `LSC_ADDR_MASK) begin
                    mask_q <= w_strb_q[0] ? w_data_q[`LSC_FLAG_W-1:0] :
                        mask_q;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `LSC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready &&
                s_axi_arvalid;
            if (do_read) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= known_addr(s_axi_araddr) ? `LSC_RESP_OKAY :
                    `LSC_RESP_SLVERR;
                case (s_axi_araddr)
                    `LSC_ADDR_CTRL: s_axi_rdata <= {24'h00_0000, ctrl_q};
                    `LSC_ADDR_STAT: s_axi_rdata <= {27'h000_0000, flags_q};
                    `LSC_ADDR_IRQ: s_axi_rdata <= {27'h000_0000, irq_stat_q};
                    `LSC_ADDR_MASK: s_axi_rdata <= {27'h000_0000, mask_q};
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // overload protection state machine
    // ----------------------------------------------------------------
    localparam [2:0] OL_IDLE = 3'b001;
    localparam [2:0] OL_ON = 3'b010;
    localparam [2:0] OL_OFF = 3'b100;
    reg [2:0] ol_state_q;
    reg [9:0] ol_ms_q;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ol_state_q <= OL_IDLE;
            ol_ms_q <= 10'h000;
        end else if (uv_s || !ctrl_q[`LSC_C_EN] || ctrl_q[`LSC_C_CLAMP]) begin
            ol_state_q <= OL_IDLE;
            ol_ms_q <= 10'h000;
        end else begin
            case (ol_state_q)
                OL_IDLE: begin
                    if (ol_s) begin
                        ol_state_q <= OL_ON;
                        ol_ms_q <= 10'h000;
                    end
                end
                OL_ON: begin
                    if (!ol_s) begin
                        ol_state_q <= OL_IDLE;
                        ol_ms_q <= 10'h000;
                    end else if (ms_tick_q) begin
                        if (ol_ms_q == `LSC_OL_ON_MS - 1) begin
                            ol_state_q <= OL_OFF;
                            ol_ms_q <= 10'h000;
                        end else begin
                            ol_ms_q <= ol_ms_q + 10'h001;
                        end
                    end
                end
                OL_OFF: begin
                    if (ms_tick_q) begin
                        if (ol_ms_q == `LSC_OL_OFF_MS - 1) begin
                            ol_state_q <= ol_s ? OL_ON : OL_IDLE;
                            ol_ms_q <= 10'h000;
                        end else begin
                            ol_ms_q <= ol_ms_q + 10'h001;
                        end
                    end
                end
                default: begin
                    ol_state_q <= OL_IDLE;
                    ol_ms_q <= 10'h000;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // flags and interrupt
    // ----------------------------------------------------------------
    wire ol_flag_d = ol_s && ctrl_q[`LSC_C_EN];

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            flags_q <= `LSC_FLAG_RST;
            flags_prev_q <= `LSC_FLAG_RST;
            irq_stat_q <= `LSC_FLAG_RST;
            irq <= 1'b0;
        end else if (uv_s) begin
            flags_q <= `LSC_FLAG_RST;
            flags_prev_q <= `LSC_FLAG_RST;
            irq_stat_q <= `LSC_FLAG_RST;
            irq <= 1'b0;
        end else begin
            flags_q <= mon_s | {4'h0, ol_flag_d};
            flags_prev_q <= flags_q;
            // set wins over clear by read
            irq_stat_q <= (irq_read ? `LSC_FLAG_RST : irq_stat_q) | flag_rise;
            irq <= |(((irq_read ? `LSC_FLAG_RST : irq_stat_q) | flag_rise)
                & mask_q);
        end
    end

    // ----------------------------------------------------------------
    // output level, tone path and pin outputs
    // ----------------------------------------------------------------
    wire en = ctrl_q[`LSC_C_EN];
    wire ol_cut = (ol_state_q == OL_OFF);

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            output_level <= `LSC_LVL_OFF;
            output_enable <= 1'b0;
            push_pull_output_pin <= 1'b0;
            tone_out_en <= 1'b0;
            static_current_clamp <= 1'b0;
            diag_current_range <= 1'b0;
            bus_address <= `LSC_BUS_ADDR_LO;
            shutdown <= 1'b1;
        end else begin
            shutdown <= uv_s || !en || ol_cut;
            output_enable <= en && !uv_s && !ol_cut;
            if (!en || uv_s)
                output_level <= `LSC_LVL_OFF;
            else if (ctrl_q[`LSC_C_AUX])
                output_level <= `LSC_LVL_22V;
            else if (ctrl_q[`LSC_C_VHI] && ctrl_q[`LSC_C_LLB])
                output_level <= `LSC_LVL_19V5;
            else if (ctrl_q[`LSC_C_VHI])
                output_level <= `LSC_LVL_18V5;
            else
                output_level <= `LSC_LVL_13V4;
            // push-pull stage sits LSC_PP_OFFSET_V below the output
            push_pull_output_pin <= en && !uv_s &&
                ctrl_q[`LSC_C_TPATH];
            tone_out_en <= en && !uv_s && ctrl_q[`LSC_C_TPATH] &&
                (ctrl_q[`LSC_C_TGEN] || gate_s);
            static_current_clamp <= ctrl_q[`LSC_C_CLAMP];
            diag_current_range <= ctrl_q[`LSC_C_RANGE];
            bus_address <= addr_pin_s ? `LSC_BUS_ADDR_HI :
                `LSC_BUS_ADDR_LO;
        end
    end

endmodule // lsc_supply_ctrl
`default_nettype wire

// *** test/lsc_host_model.sv ***
/* host model on the axi4-lite register port.
   assumes one access at a time; the bench timeout ends any hang. */
`timescale 1ns/1ps
`default_nettype none
module lsc_host_model (
    input wire logic mclk,
    output logic [3:0] s_axi_awaddr = 4'h0,
    output logic s_axi_awvalid = 1'b0,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata = 32'h0,
    output logic [3:0] s_axi_wstrb = 4'h1,
    output logic s_axi_wvalid = 1'b0,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready = 1'b0,
    output logic [3:0] s_axi_araddr = 4'h0,
    output logic s_axi_arvalid = 1'b0,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready = 1'b0
);
int slow = 0;
logic [31:0] rdata_q;
logic [1:0] bresp_q = 2'b00;
logic [1:0] rresp_q = 2'b00;
// ----------
// bus cycles, released payload inverted
// ----------
task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = slow;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (slow == 0);
    forever begin
        @(posedge mclk);
        if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bresp_q = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
        end
        if (s_axi_bvalid && n > 0)
            n--;
        else if (s_axi_bvalid)
            s_axi_bready <= 1'b1;
    end
endtask
task automatic rd(input logic [3:0] a);
    int n;
    n = slow;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (slow == 0);
    forever begin
        @(posedge mclk);
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            rdata_q = s_axi_rdata;
            rresp_q = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
        end
        if (s_axi_rvalid && n > 0)
            n--;
        else if (s_axi_rvalid)
            s_axi_rready <= 1'b1;
    end
endtask
endmodule // lsc_host_model
`default_nettype wire

// *** test/lsc_supply_ctrl_properties.sv ***
/* assertions on the dish supply control ports.
   assumes one clock, mclk, and async active-low reset_n. */
`timescale 1ns/1ps
`default_nettype none
module lsc_supply_ctrl_chk #(
    parameter [31:0] MS_CYCLES = 4
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic addr_sel_pin,
    input wire logic undervoltage_in,
    input wire logic overload_in,
    input wire logic [2:0] output_level,
    input wire logic output_enable,
    input wire logic push_pull_output_pin,
    input wire logic tone_out_en,
    input wire logic static_current_clamp,
    input wire logic [6:0] bus_address,
    input wire logic shutdown,
    input wire logic irq
);
// ----------
// overload period counters
// ----------
localparam [31:0] ON_LO = 89 * MS_CYCLES - 2;
localparam [31:0] ON_HI = 91 * MS_CYCLES + 6;
localparam [31:0] OFF_LO = 899 * MS_CYCLES - 2;
localparam [31:0] OFF_HI = 901 * MS_CYCLES + 6;
logic [31:0] on_cnt_q;
logic [31:0] off_cnt_q;
always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        on_cnt_q <= 32'h0;
        off_cnt_q <= 32'h0;
    end else begin
        on_cnt_q <= (output_enable && overload_in) ? on_cnt_q + 1 : 32'h0;
        off_cnt_q <= output_enable ? 32'h0 : off_cnt_q + 1;
    end
end
default clocking cb @(posedge mclk); endclocking
default disable iff (!reset_n);
a_addr_high: assert property (
    addr_sel_pin [*5] |-> bus_address == 7'h03) else $error("addr not 03");
a_addr_low: assert property (
    !addr_sel_pin [*5] |-> bus_address == 7'h02) else $error("addr not 02");
a_tone_needs_path: assert property (
    tone_out_en |-> push_pull_output_pin) else $error("tone without path");
a_uv_shutdown: assert property (
    undervoltage_in [*5] |-> shutdown && output_level == 3'h0 && !irq
    && !s_axi_awready) else $error("undervoltage not shut down");
a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid drop");
a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata unstable");
a_ol_on_time: assert property (
    $fell(output_enable) && overload_in && !static_current_clamp
    && !undervoltage_in |-> on_cnt_q >= ON_LO && on_cnt_q <= ON_HI)
    else $error("overload on period wrong");
a_ol_off_time: assert property (
    $rose(output_enable) && overload_in |-> off_cnt_q >= OFF_LO
    && off_cnt_q <= OFF_HI) else $error("overload off period wrong");
a_clamp_steady: assert property (
    static_current_clamp && output_enable && overload_in
    |=> output_enable || !static_current_clamp) else $error("clamp cycled");
endmodule // lsc_supply_ctrl_chk
bind lsc_supply_ctrl lsc_supply_ctrl_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
    .mclk, .reset_n, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .addr_sel_pin,
    .undervoltage_in, .overload_in, .output_level, .output_enable,
    .push_pull_output_pin, .tone_out_en, .static_current_clamp,
    .bus_address, .shutdown, .irq);
`default_nettype wire

// *** test/tb_top.sv ***
/* self-checking bench of the dish supply control block.
   assumes the host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
localparam [31:0] MS = 4;
logic mclk, reset_n, addr_sel_pin, tone_gate_pin, undervoltage_in;
logic [4:0] mon;
wire logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
wire logic [31:0] s_axi_wdata, s_axi_rdata;
wire logic [1:0] s_axi_bresp, s_axi_rresp;
wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
wire logic s_axi_rvalid, s_axi_rready, output_enable, shutdown, irq;
wire logic push_pull_output_pin, tone_out_en, static_current_clamp;
wire logic diag_current_range;
wire logic [2:0] output_level;
wire logic [6:0] bus_address;
wire logic overload_in = mon[0];
wire logic overheat_in = mon[1];
wire logic tone_bad_in = mon[2];
wire logic vout_low_in = mon[3];
wire logic min_current_in = mon[4];
int n_mismatch = 0;
int cmp_count = 0;
int cyc = 0;
int ctl_q[$] = '{8'h01, 8'h03, 8'h07, 8'hc1, 8'h19, 8'h11};
lsc_supply_ctrl #(.MS_CYCLES(MS)) uut (.*);
lsc_host_model host (.*);
// ----------
// compare and model tasks
// ----------
task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
        n_mismatch++;
        $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
endtask
task automatic tick(input int n);
    repeat (n) @(posedge mclk);
endtask
task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    host.rd(a);
    chk(host.rdata_q, exp);
    chk(host.rresp_q, (a[1:0] != 2'b00) ? 32'h2 : 32'h0);
endtask
task automatic chk_out(input int c);
    logic [2:0] lv;
    lv = !c[0] ? 3'h0 : c[7] ? 3'h4 : !c[1] ? 3'h1 : c[2] ? 3'h3 : 3'h2;
    chk({25'h0, output_level, push_pull_output_pin, tone_out_en,
        static_current_clamp, diag_current_range}, {25'h0, lv, c[0] & c[4],
        c[0] & c[4] & (c[3] | tone_gate_pin), c[5], c[6]});
endtask
initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
end
always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
        n_mismatch++;
        tally_and_finish();
    end
end
initial begin
    int n;
    reset_n = 1'b0;
    addr_sel_pin = 1'b0;
    tone_gate_pin = 1'b0;
    undervoltage_in = 1'b0;
    mon = 5'h00;
    void'($urandom(32'he5a2));
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    tick(2);
    chk(shutdown, 1'b1);
    rd_chk(4'h0, 32'h0);
    for (int i = 0; i < 12; i++)
        ctl_q.push_back($urandom);
    foreach (ctl_q[i]) begin
        tone_gate_pin <= ctl_q[i][8];
        host.wr(4'h0, ctl_q[i]);
        tick(4);
        chk_out(ctl_q[i]);
        rd_chk(4'h0, ctl_q[i] & 32'h0000_00ff);
    end
    addr_sel_pin <= 1'b1;
    tick(5);
    chk(bus_address, 7'h03);
    addr_sel_pin <= 1'b0;
    tick(5);
    chk(bus_address, 7'h02);
    host.wr(4'h6, 32'h0000_00ff);
    chk(host.bresp_q, 32'h2);
    rd_chk(4'h6, 32'h0);
    host.wr(4'h0, 32'h0000_0001);
    chk(host.bresp_q, 32'h0);
    rd_chk(4'h0, 32'h0000_0001);
    tone_gate_pin <= 1'b0;
    for (int t = 0; t < 2; t++) begin
        host.wr(4'h0, 32'h13 | (t << 3));
        tick(MS / 2 + 1);
        host.wr(4'h0, 32'h11 | (t << 3));
        tick(t ? 25 * MS : 30 * MS);
        chk_out(32'h11 | (t << 3));
        host.wr(4'h0, 32'h01);
    end
    $display("test levels done");
    host.slow = 3;
    host.wr(4'h0, 32'h21);
    host.wr(4'hc, 32'h1f);
    for (int i = 0; i < 5; i++) begin
        mon <= 5'h01 << i;
        tick(5);
        rd_chk(4'h4, 32'h1 << i);
        chk(irq, 1'b1);
        rd_chk(4'h8, 32'h1 << i);
        mon <= 5'h00;
        tick(5);
        rd_chk(4'h4, 32'h0);
        rd_chk(4'h8, 32'h0);
        chk(irq, 1'b0);
    end
    host.wr(4'hc, 32'h0);
    mon <= 5'h08;
    tick(5);
    chk(irq, 1'b0);
    rd_chk(4'h8, 32'h8);
    mon <= 5'h00;
    host.slow = 0;
    $display("test flags done");
    host.wr(4'h0, 32'h01);
    mon <= 5'h01;
    n = 0;
    while (output_enable === 1'b1 && n < 1000) begin
        @(posedge mclk);
        n++;
    end
    chk(n >= 89 * MS && n <= 92 * MS, 1'b1);
    rd_chk(4'h4, 32'h1);
    n = 0;
    while (output_enable !== 1'b1 && n < 5000) begin
        @(posedge mclk);
        n++;
    end
    chk(n >= 895 * MS && n <= 901 * MS, 1'b1);
    tick(5);
    chk(output_enable, 1'b1);
    mon <= 5'h00;
    tick(6);
    rd_chk(4'h4, 32'h0);
    chk(output_enable, 1'b1);
    tick(92 * MS);
    chk(output_enable, 1'b1);
    host.wr(4'h0, 32'h21);
    mon <= 5'h01;
    tick(92 * MS);
    chk(output_enable, 1'b1);
    rd_chk(4'h4, 32'h1);
    mon <= 5'h00;
    host.wr(4'hc, 32'h1f);
    undervoltage_in <= 1'b1;
    tick(5);
    chk({shutdown, output_level, output_enable}, 5'h10);
    undervoltage_in <= 1'b0;
    tick(5);
    rd_chk(4'h0, 32'h0);
    rd_chk(4'hc, 32'h0);
    $display("test protection done");
    tally_and_finish();
end
endmodule // tb_top
`default_nettype wire
